/* File: verilog/ysw_pkg.sv */
// Constants and types for the converter frame-buffer write addressing block
package ysw_pkg;

    // Register indices; the bus byte address is four times the index
    localparam logic [15:0] IDX_CTRL      = 16'h3000;
    localparam logic [15:0] IDX_BASE_A_LO = 16'h3002;
    localparam logic [15:0] IDX_BASE_A_HI = 16'h3004;
    localparam logic [15:0] IDX_BASE_B_LO = 16'h3006;
    localparam logic [15:0] IDX_BASE_B_HI = 16'h3008;
    localparam logic [15:0] IDX_RSVD_0    = 16'h300a;
    localparam logic [15:0] IDX_RSVD_1    = 16'h300c;
    localparam logic [15:0] IDX_UV_FIX    = 16'h300e;
    localparam logic [15:0] IDX_RECT_W    = 16'h3010;
    localparam logic [15:0] IDX_RECT_PITCH = 16'h3012;
    localparam logic [15:0] IDX_STATUS    = 16'h3014;

    localparam int unsigned APB_ADDR_W = 18;

    // Control register fields
    localparam int unsigned CTRL_RECT_BIT  = 14;
    localparam int unsigned CTRL_DBL_BIT   = 12;
    localparam int unsigned CTRL_SRST_BIT  = 7;
    localparam int unsigned CTRL_UVSEL_HI  = 6;
    localparam int unsigned CTRL_UVSEL_LO  = 5;
    localparam int unsigned CTRL_BPP16_BIT = 3;
    localparam logic [15:0] CTRL_RST       = 16'h0005;

    // Address field layout
    localparam int unsigned BASE_W      = 26;
    localparam int unsigned BASE_HI_W   = 10;
    localparam int unsigned RECT_W_W    = 11;
    localparam int unsigned RECT_P_W    = 12;
    localparam logic [25:0] BASE_A_RST  = 26'h0000000;
    localparam logic [25:0] BASE_B_RST  = 26'h0000000;
    localparam logic [15:0] UV_FIX_RST  = 16'h0000;
    localparam logic [10:0] RECT_W_RST  = 11'h000;
    localparam logic [11:0] RECT_P_RST  = 12'h000;
    localparam logic [25:0] WORD_STEP   = 26'h0000004;

    // Status register fields
    localparam int unsigned STAT_ACT_BIT = 0;
    localparam int unsigned STAT_BUF_LO  = 1;

    localparam int unsigned FIFO_DEPTH = 16;

    // One 32-bit word of packed chroma/luma input
    typedef struct packed {
        logic [7:0] y1;
        logic [7:0] u;
        logic [7:0] y0;
        logic [7:0] v;
    } ysw_word_t;

    // One write toward the frame memory
    typedef struct packed {
        logic [25:0] addr;
        logic [31:0] data;
    } ysw_mem_req_t;

endpackage

/* File: verilog/ysw_fifo.sv */
// Synchronous valid/ready FIFO with parameterised width and depth
`timescale 1ns/1ps
`default_nettype none
module ysw_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wp_q;
    logic [PW-1:0]    rp_q;
    logic [PW:0]      cnt_q;
    logic [PW:0]      cnt_d;
    logic             in_ready_q;
    logic             push;
    logic             pop;

    assign push      = in_valid && in_ready_q;
    assign pop       = out_valid && out_ready;
    assign in_ready  = in_ready_q;
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rp_q];

    always_comb begin
        cnt_d = cnt_q;
        if (flush) begin
            cnt_d = '0;
        end else if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // Ready is registered so the source never sees a combinational path
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q       <= '0;
            rp_q       <= '0;
            cnt_q      <= '0;
            in_ready_q <= 1'b0;
        end else begin
            cnt_q      <= cnt_d;
            in_ready_q <= (cnt_d != DEPTH[PW:0]) && !flush;
            if (flush) begin
                wp_q <= '0;
                rp_q <= '0;
            end else begin
                if (push) begin
                    wp_q <= (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
                end
                if (pop) begin
                    rp_q <= (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (push && !flush) begin
            mem_q[wp_q] <= in_data;
        end
    end

endmodule
`default_nettype wire

/* File: verilog/ysw_frame_writer.sv */
// Frame-buffer write addressing with APB registers and chroma override
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
//
// Operation
// [RL1] Primary base used only for converter writes
// [RL2] Single buffer mode starts at primary base
// [RL3] Double mode: first buffer at primary base
// [RL4] Double mode: second buffer at secondary base
// [RL5] Secondary base ignored in single mode
// [RL6] Base split: low 16, high 10 bits
// [RL7] Writes are 32-bit, bases word aligned
// [RL8] Select 10b/11b replaces V with low byte
// [RL9] Override register: U high byte, V low
// [RL10] Select 01b/11b replaces U with high byte
// [RL11] Rectangular mode: 11-bit line width in pixels
// [RL12] At 16 bpp width uses bits 10-1
// [RL13] Software leaves reserved registers unwritten
// [RL14] Activity flag high while writing memory
// [RL15] Address advances four bytes per write
module ysw_frame_writer
    import ysw_pkg::*;
#(
    parameter int unsigned DEPTH = ysw_pkg::FIFO_DEPTH
) (
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [ysw_pkg::APB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]                    pwdata,
    output logic [31:0]                         prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic                           frame_start,
    input  wire logic                           pix_valid,
    output logic                                pix_ready,
    input  wire ysw_pkg::ysw_word_t             pix_word,
    output logic                                mem_wvalid,
    input  wire logic                           mem_wready,
    output ysw_pkg::ysw_mem_req_t               mem_req,
    output logic                                frame_active
);
    import ysw_pkg::*;

    logic [15:0]     ctrl_q;
    logic [25:0]     base_a_q;
    logic [25:0]     base_b_q;
    logic [15:0]     uv_fix_q;
    logic [10:0]     rect_w_q;
    logic [11:0]     rect_p_q;
    logic [31:0]     prdata_q;
    logic            pready_q;
    logic            pslverr_q;
    logic [15:0]     idx;
    logic            aligned;
    logic            hit;
    logic            wr_en;
    logic [31:0]     rd_d;

    logic            dbl;
    logic            rect;
    logic            bpp16;
    logic            srst;
    logic [1:0]      uv_sel;
    ysw_word_t       fix_word;
    logic            fifo_in_ready;
    logic            fifo_valid;
    logic [31:0]     fifo_data;
    logic            pop;
    logic            next_buf_q;
    logic            cur_buf_q;
    logic            sel_buf;
    logic [25:0]     start_addr;
    logic [25:0]     addr_q;
    logic [25:0]     line_base_q;
    logic [10:0]     word_cnt_q;
    logic [10:0]     width_words;
    logic [25:0]     pitch_bytes;
    logic            line_wrap;
    logic            active_q;
    logic            act_flag_q;
    ysw_mem_req_t    req_q;
    logic            wvalid_q;

    assign dbl    = ctrl_q[CTRL_DBL_BIT];
    assign rect   = ctrl_q[CTRL_RECT_BIT];
    assign bpp16  = ctrl_q[CTRL_BPP16_BIT];
    assign srst   = ctrl_q[CTRL_SRST_BIT];
    assign uv_sel = ctrl_q[CTRL_UVSEL_HI:CTRL_UVSEL_LO];

    // APB decode: byte address is four times the register index
    assign idx     = paddr[17:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign wr_en   = psel && penable && pready_q && pwrite && !pslverr_q;

    always_comb begin
        hit  = aligned;
        rd_d = 32'h00000000;
        case (idx)
            IDX_CTRL:       rd_d[15:0] = ctrl_q;
            IDX_BASE_A_LO:  rd_d[15:0] = base_a_q[15:0];               // see [RL6]
            IDX_BASE_A_HI:  rd_d[9:0]  = base_a_q[25:16];              // see [RL6]
            IDX_BASE_B_LO:  rd_d[15:0] = base_b_q[15:0];
            IDX_BASE_B_HI:  rd_d[9:0]  = base_b_q[25:16];
            IDX_RSVD_0:     rd_d       = 32'h00000000;
            IDX_RSVD_1:     rd_d       = 32'h00000000;
            IDX_UV_FIX:     rd_d[15:0] = uv_fix_q;                     // see [RL9]
            IDX_RECT_W:     rd_d[10:0] = rect_w_q;
            IDX_RECT_PITCH: rd_d[11:0] = rect_p_q;
            IDX_STATUS: begin
                rd_d[STAT_ACT_BIT] = act_flag_q;                       // see [RL14]
                rd_d[STAT_BUF_LO]  = cur_buf_q;
            end
            default:        hit = 1'b0;
        endcase
    end

    // One wait-free access phase; answer prepared during setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= psel && !penable;
            pslverr_q <= psel && !penable && !hit;
            if (psel && !penable && !pwrite) begin
                prdata_q <= hit ? rd_d : 32'h00000000;
            end
        end
    end

    // Reserved words accept writes but keep nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q   <= CTRL_RST;
            base_a_q <= BASE_A_RST;
            base_b_q <= BASE_B_RST;
            uv_fix_q <= UV_FIX_RST;
            rect_w_q <= RECT_W_RST;
            rect_p_q <= RECT_P_RST;
        end else if (wr_en) begin
            case (idx)
                IDX_CTRL:       ctrl_q            <= pwdata[15:0];
                IDX_BASE_A_LO:  base_a_q[15:0]    <= pwdata[15:0];     // see [RL6]
                IDX_BASE_A_HI:  base_a_q[25:16]   <= pwdata[9:0];      // see [RL6]
                IDX_BASE_B_LO:  base_b_q[15:0]    <= pwdata[15:0];
                IDX_BASE_B_HI:  base_b_q[25:16]   <= pwdata[9:0];
                IDX_UV_FIX:     uv_fix_q          <= pwdata[15:0];
                IDX_RECT_W:     rect_w_q          <= pwdata[10:0];
                IDX_RECT_PITCH: rect_p_q          <= pwdata[11:0];
                default: begin
                end
            endcase
        end
    end

    // Chroma override ahead of the buffer
    always_comb begin
        fix_word = pix_word;
        if (uv_sel[0]) begin
            fix_word.u = uv_fix_q[15:8];                               // see [RL10] [RL9]
        end
        if (uv_sel[1]) begin
            fix_word.v = uv_fix_q[7:0];                                // see [RL8] [RL9]
        end
    end

    ysw_fifo #(
        .WIDTH (32),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .flush     (srst),
        .in_valid  (pix_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fix_word),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .out_data  (fifo_data)
    );

    // Secondary base reachable only with double buffering on
    assign sel_buf    = dbl ? next_buf_q : 1'b0;                       // see [RL5]
    assign start_addr = sel_buf ? {base_b_q[25:2], 2'b00}              // see [RL4] [RL7]
                                : {base_a_q[25:2], 2'b00};             // see [RL2] [RL3] [RL1]

    // 16 bpp packs two pixels per word, so the width's low bit drops
    assign width_words = bpp16 ? {1'b0, rect_w_q[10:1]} : rect_w_q;   // see [RL12]
    assign pitch_bytes = bpp16 ? {13'h0000, rect_p_q[11:1], 2'b00}
                               : {12'h000, rect_p_q, 2'b00};
    assign line_wrap   = rect && (width_words != 11'h000)               // see [RL11]
                         && (word_cnt_q == width_words - 11'h001);
    assign pop = active_q && fifo_valid && (!wvalid_q || mem_wready);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            next_buf_q <= 1'b0;
            cur_buf_q  <= 1'b0;
            active_q   <= 1'b0;
        end else if (srst) begin
            next_buf_q <= 1'b0;
            cur_buf_q  <= 1'b0;
            active_q   <= 1'b0;
        end else if (frame_start) begin
            cur_buf_q  <= sel_buf;
            next_buf_q <= dbl ? !sel_buf : 1'b0;
            active_q   <= 1'b1;
        end
    end

    // Address walk; a new frame reloads the selected base
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q      <= 26'h0000000;
            line_base_q <= 26'h0000000;
            word_cnt_q  <= 11'h000;
        end else if (frame_start && !srst) begin
            addr_q      <= start_addr;
            line_base_q <= start_addr;
            word_cnt_q  <= 11'h000;
        end else if (pop) begin
            if (line_wrap) begin
                addr_q      <= line_base_q + pitch_bytes;              // see [RL11]
                line_base_q <= line_base_q + pitch_bytes;
                word_cnt_q  <= 11'h000;
            end else begin
                addr_q     <= addr_q + WORD_STEP;                      // see [RL15]
                word_cnt_q <= word_cnt_q + 11'h001;
            end
        end
    end

    // Request held until the memory takes it or soft reset drops it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wvalid_q <= 1'b0;
            req_q    <= '0;
        end else if (pop) begin
            wvalid_q   <= 1'b1;
            req_q.addr <= {addr_q[25:2], 2'b00};                       // see [RL7]
            req_q.data <= fifo_data;
        end else if (mem_wready || srst) begin
            wvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_flag_q <= 1'b0;
        end else begin
            act_flag_q <= wvalid_q || (active_q && fifo_valid);        // see [RL14]
        end
    end

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign pix_ready    = fifo_in_ready;
    assign mem_wvalid   = wvalid_q;
    assign mem_req      = req_q;
    assign frame_active = active_q;

    single_base_a: assert property (@(posedge pclk) disable iff (!presetn)   // see [RL2]
        frame_start && !srst && !dbl |=> addr_q == {base_a_q[25:2], 2'b00} && !cur_buf_q)
        else $error("single mode did not start at primary base");

    dbl_first_a: assert property (@(posedge pclk) disable iff (!presetn)     // see [RL3]
        frame_start && !srst && dbl && !next_buf_q
        |=> !cur_buf_q && addr_q == {base_a_q[25:2], 2'b00})
        else $error("first buffer not at primary base");

    dbl_second_a: assert property (@(posedge pclk) disable iff (!presetn)    // see [RL4]
        frame_start && !srst && dbl && next_buf_q
        |=> cur_buf_q && addr_q == {base_b_q[25:2], 2'b00})
        else $error("second buffer not at secondary base");

    single_ignore_b_a: assert property (@(posedge pclk) disable iff (!presetn) // see [RL5]
        frame_start && !srst && !dbl |=> !next_buf_q ##1 !cur_buf_q || dbl)
        else $error("secondary base used in single mode");

    word_align_a: assert property (@(posedge pclk) disable iff (!presetn)    // see [RL7]
        mem_wvalid |-> mem_req.addr[1:0] == 2'b00)
        else $error("unaligned memory write");

    base_split_a: assert property (@(posedge pclk) disable iff (!presetn)    // see [RL6]
        wr_en && idx == IDX_BASE_A_HI |=> base_a_q[25:16] == $past(pwdata[9:0]))
        else $error("primary base high part not stored");

    v_fix_a: assert property (@(posedge pclk) disable iff (!presetn)         // see [RL8]
        uv_sel[1] |-> fix_word.v == uv_fix_q[7:0] && fix_word.y0 == pix_word.y0)
        else $error("V override not applied");

    u_fix_a: assert property (@(posedge pclk) disable iff (!presetn)         // see [RL10]
        uv_sel[0] |-> fix_word.u == uv_fix_q[15:8] && fix_word.y1 == pix_word.y1)
        else $error("U override not applied");

    uv_pass_a: assert property (@(posedge pclk) disable iff (!presetn)       // see [RL9]
        uv_sel == 2'b00 |-> fix_word == pix_word)
        else $error("chroma altered without override");

    addr_step_a: assert property (@(posedge pclk) disable iff (!presetn)     // see [RL15]
        pop && !line_wrap && !frame_start |=> addr_q == $past(addr_q) + WORD_STEP)
        else $error("address did not advance by four");

    rect_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)     // see [RL11] [RL12]
        pop && line_wrap && !frame_start
        |=> word_cnt_q == 11'h000 && addr_q == $past(line_base_q) + $past(pitch_bytes))
        else $error("rectangle line did not wrap");

    write_hold_a: assert property (@(posedge pclk) disable iff (!presetn)    // see [RL1]
        mem_wvalid && !mem_wready && !srst |=> mem_wvalid && $stable(mem_req))
        else $error("pending write dropped or changed");

    activity_a: assert property (@(posedge pclk) disable iff (!presetn)      // see [RL14]
        mem_wvalid |=> act_flag_q)
        else $error("activity flag low during write");

    base_low_a: assert property (@(posedge pclk) disable iff (!presetn)      // see [RL6]
        wr_en && idx == IDX_BASE_B_LO |=> base_b_q[15:0] == $past(pwdata[15:0]))
        else $error("secondary base low part not stored");

    linear_walk_a: assert property (@(posedge pclk) disable iff (!presetn)   // see [RL11]
        pop && !rect && !frame_start |=> addr_q == $past(addr_q) + WORD_STEP)
        else $error("line wrap outside rectangular mode");

    half_width_a: assert property (@(posedge pclk) disable iff (!presetn)    // see [RL12]
        bpp16 |-> width_words == 11'(rect_w_q >> 1))
        else $error("odd width bit used at 16 bpp");

    status_read_a: assert property (@(posedge pclk) disable iff (!presetn)   // see [RL14]
        psel && !penable && !pwrite && idx == IDX_STATUS && aligned
        |=> prdata[STAT_ACT_BIT] == $past(act_flag_q))
        else $error("status read lost activity flag");

    single_sel_a: assert property (@(posedge pclk) disable iff (!presetn)    // see [RL5]
        !dbl |-> start_addr == {base_a_q[25:2], 2'b00})
        else $error("secondary base selected in single mode");

endmodule
`default_nettype wire

/* File: verif/ysw_mem_model.sv */
// Behavioural frame memory that takes converter writes, with stall and slow modes
`timescale 1ns/1ps
`default_nettype none
module ysw_mem_model
    import ysw_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  stall,
    input  wire logic                  slow,
    input  wire logic                  mem_wvalid,
    output logic                       mem_wready,
    input  wire ysw_pkg::ysw_mem_req_t mem_req
);
    ysw_mem_req_t q[$];

    // Slow mode answers every other cycle, so a request must hold through gaps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_wready <= 1'b0;
        end else begin
            mem_wready <= !stall && (!slow || !mem_wready);
        end
    end

    // One accepted request is one whole 32-bit word
    always @(posedge pclk) begin
        if (presetn && mem_wvalid && mem_wready) begin
            q.push_back(mem_req);
        end
    end
endmodule
`default_nettype wire

/* File: verif/tb_yuv_rgb_frame_write_addressing.sv */
// Self-checking bench: registers, buffer addressing, chroma override, FIFO
`timescale 1ns/1ps
`default_nettype none
module tb_yuv_rgb_frame_write_addressing;
    import ysw_pkg::*;
    localparam logic [25:0] BA = 26'h1234560;
    localparam logic [25:0] BB = 26'h2abc000;
    logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [APB_ADDR_W-1:0] paddr;
    logic [31:0]           pwdata, prdata, rdata;
    logic                  frame_start, pix_valid, pix_ready, mem_wvalid, mem_wready;
    logic                  frame_active, err, stall, slow;
    ysw_word_t             pix_word;
    ysw_mem_req_t          mem_req;
    logic [25:0]           ea;
    logic [7:0]            eu, ev;
    int                    error_cnt, samples_checked, cnt;

    ysw_frame_writer #(.DEPTH(FIFO_DEPTH)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .frame_start(frame_start),
        .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_word(pix_word),
        .mem_wvalid(mem_wvalid), .mem_wready(mem_wready), .mem_req(mem_req),
        .frame_active(frame_active));

    ysw_mem_model mem (
        .pclk(pclk), .presetn(presetn), .stall(stall), .slow(slow),
        .mem_wvalid(mem_wvalid), .mem_wready(mem_wready), .mem_req(mem_req));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic stuck();
        error_cnt++;
        final_report();
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Master holds the request until pready is seen high, then releases
    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
        int k;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) stuck();
        rdata = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic fs();
        frame_start <= 1'b1;
        @(posedge pclk);
        frame_start <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic push(input ysw_word_t w);
        int k;
        pix_valid <= 1'b1;
        pix_word  <= w;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pix_ready !== 1'b1 && k < 200);
        if (k >= 200) stuck();
        pix_valid <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic exp_wr(input logic [25:0] a, input logic [31:0] d);
        int k;
        k = 0;
        while (mem.q.size() == 0 && k < 300) begin
            @(posedge pclk);
            k++;
        end
        if (mem.q.size() == 0) stuck();
        chk("wr_addr", {6'h0, mem.q[0].addr}, {6'h0, a});
        chk("wr_data", mem.q[0].data, d);
        void'(mem.q.pop_front());
    endtask

    initial begin
        repeat (100000) @(posedge pclk);
        stuck();
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, frame_start, pix_valid, stall, slow} = '0;
        paddr = '0;
        pwdata = '0;
        pix_word = '0;
        error_cnt = 0;
        samples_checked = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, IDX_BASE_B_LO, 32'h0);
        chk("base_b_lo_rst", rdata, 32'h0);
        apb(1'b0, IDX_BASE_B_HI, 32'h0);
        chk("base_b_hi_rst", rdata, 32'h0);
        apb(1'b0, IDX_CTRL, 32'h0);
        chk("ctrl_rst", rdata, {16'h0, CTRL_RST});
        apb(1'b1, IDX_BASE_A_HI, 32'hffffffff);
        apb(1'b0, IDX_BASE_A_HI, 32'h0);
        chk("base_a_hi_mask", rdata, 32'h3ff);
        // Reserved words are only read, never written
        apb(1'b0, IDX_RSVD_0, 32'h0);
        chk("rsvd_read", rdata, 32'h0);
        apb(1'b1, IDX_STATUS, 32'hffff);
        apb(1'b0, IDX_STATUS, 32'h0);
        chk("status_idle", rdata, 32'h0);
        apb(1'b0, 16'h3fff, 32'h0);
        chk("unmapped_err", {31'h0, err}, 32'h1);
        apb(1'b1, IDX_BASE_A_LO, {16'h0, BA[15:0]});
        apb(1'b1, IDX_BASE_A_HI, {22'h0, BA[25:16]});
        apb(1'b1, IDX_BASE_B_LO, {16'h0, BB[15:0]});
        apb(1'b1, IDX_BASE_B_HI, {22'h0, BB[25:16]});
        // Single buffer: secondary base programmed but must stay unused
        apb(1'b1, IDX_CTRL, 32'h0005);
        fs();
        chk("frame_active", {31'h0, frame_active}, 32'h1);
        slow <= 1'b1;
        for (int i = 0; i < 3; i++) push(32'h10203040 + i);
        for (int i = 0; i < 3; i++) exp_wr(BA + 26'(4 * i), 32'h10203040 + i);
        stall <= 1'b1;
        push(32'h55);
        cnt = 0;
        while (mem_wvalid !== 1'b1 && cnt < 50) begin
            @(posedge pclk);
            cnt++;
        end
        if (cnt >= 50) stuck();
        apb(1'b0, IDX_STATUS, 32'h0);
        chk("status_busy", {31'h0, rdata[STAT_ACT_BIT]}, 32'h1);
        stall <= 1'b0;
        exp_wr(BA + 26'hc, 32'h55);
        apb(1'b0, IDX_STATUS, 32'h0);
        apb(1'b0, IDX_STATUS, 32'h0);
        chk("status_done", {31'h0, rdata[STAT_ACT_BIT]}, 32'h0);
        ea = BA + 26'h10;
        apb(1'b1, IDX_UV_FIX, 32'h0000abcd);
        apb(1'b0, IDX_UV_FIX, 32'h0);
        chk("uv_fix_rb", rdata, 32'h0000abcd);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, IDX_CTRL, 32'h5 | (s << 5));
            eu = s[0] ? 8'hab : 8'h22;
            ev = s[1] ? 8'hcd : 8'h44;
            push(32'h11223344);
            exp_wr(ea, {8'h11, eu, 8'h33, ev});
            ea = ea + 26'h4;
        end
        // Rectangle of two words per line, pitch of eight pixels
        apb(1'b1, IDX_RECT_W, 32'h2);
        apb(1'b1, IDX_RECT_PITCH, 32'h8);
        apb(1'b1, IDX_CTRL, 32'h4005);
        fs();
        for (int i = 0; i < 3; i++) push(32'h70 + i);
        exp_wr(BA, 32'h70);
        exp_wr(BA + 26'h4, 32'h71);
        exp_wr(BA + 26'h20, 32'h72);
        // Odd width at 16 bpp: bit 0 dropped, so two words per line
        apb(1'b1, IDX_RECT_W, 32'h5);
        apb(1'b1, IDX_CTRL, 32'h400d);
        fs();
        for (int i = 0; i < 3; i++) push(32'h80 + i);
        exp_wr(BA, 32'h80);
        exp_wr(BA + 26'h4, 32'h81);
        exp_wr(BA + 26'h10, 32'h82);
        apb(1'b1, IDX_CTRL, 32'h1005);
        for (int f = 0; f < 3; f++) begin
            fs();
            push(32'h90 + f);
            exp_wr(f == 1 ? BB : BA, 32'h90 + f);
            apb(1'b0, IDX_STATUS, 32'h0);
            chk("cur_buf", {31'h0, rdata[STAT_BUF_LO]}, 32'(f == 1));
        end
        apb(1'b1, IDX_CTRL, 32'h0005);
        fs();
        push(32'h99);
        exp_wr(BA, 32'h99);
        // Soft reset stops the frame, so the FIFO fills with no drain
        apb(1'b1, IDX_CTRL, 32'h0085);
        // Flag falls on the edge the bus task returns at; look one edge later
        @(posedge pclk);
        chk("soft_rst_idle", {31'h0, frame_active}, 32'h0);
        apb(1'b1, IDX_CTRL, 32'h0005);
        cnt = 0;
        pix_valid <= 1'b1;
        pix_word  <= 32'h5a000000;
        for (int k = 0; k < 40; k++) begin
            @(posedge pclk);
            if (pix_ready === 1'b1) begin
                cnt++;
                pix_word <= 32'h5a000000 + cnt;
            end
        end
        pix_valid <= 1'b0;
        chk("fifo_fill", cnt, FIFO_DEPTH);
        stall <= 1'b1;
        fs();
        stall <= 1'b0;
        for (int i = 0; i < FIFO_DEPTH; i++) exp_wr(BA + 26'(4 * i), 32'h5a000000 + i);
        final_report();
    end
endmodule
`default_nettype wire
